// file: rtl/flash_prot_pkg.sv
// Package: protection modes, request structs and constants for flash protection control
package flash_prot_pkg;
    // Protection modes, Gray coded along open -> protected -> kill
    typedef enum logic [1:0] {
        MODE_OPEN = 2'h0,
        MODE_PROTECTED = 2'h1,
        MODE_KILL = 2'h3
    } prot_mode_t;

    // Mode change commands
    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_TO_PROTECTED = 2'h1,
        CMD_TO_OPEN = 2'h2,
        CMD_TO_KILL = 2'h3
    } mode_cmd_t;

    // Flash operation kinds
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_ERASE = 2'h2
    } flash_op_t;

    localparam int ROW_BITS = 9;
    localparam int NUM_ROWS = 512;

    // A flash access request
    typedef struct packed {
        logic valid;
        flash_op_t op;
        logic from_debug;
        logic from_syscall;
        logic [ROW_BITS-1:0] row;
    } flash_req_t;

    // Answer to a flash access request
    typedef struct packed {
        logic done;
        logic granted;
    } flash_rsp_t;

    localparam prot_mode_t MODE_RESET = MODE_OPEN;
    localparam logic [1:0] WAIT_FAST = 2'h1;
    localparam logic [1:0] WAIT_SLOW = 2'h0;
    localparam int FAST_CLK_MHZ = 48;
    localparam int SLOW_CLK_MHZ = 24;
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
endpackage : flash_prot_pkg

// file: rtl/flash_protection_mode_control.sv
// Flash protection mode control: mode machine, debug gate, row protection, wait states
`timescale 1ns/1ps

module flash_protection_mode_control #(
    parameter int ROWS = flash_prot_pkg::NUM_ROWS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Mode change request and stored mode (nonvolatile copy restored at power-up)
    input wire flash_prot_pkg::mode_cmd_t mode_cmd,
    input wire logic mode_cmd_valid,
    input wire logic stored_mode_valid,
    input wire flash_prot_pkg::prot_mode_t stored_mode,
    // Full-erase completion from the flash array
    input wire logic full_erase_done,
    // Row protection programming
    input wire logic row_prot_we,
    input wire logic [flash_prot_pkg::ROW_BITS-1:0] row_prot_row,
    input wire logic row_prot_wr_block,
    input wire logic row_prot_rd_block,
    // Flash access request and clock rate select (1 = 48 MHz, 0 = 24 MHz)
    input wire flash_prot_pkg::flash_req_t flash_req,
    input wire logic fast_clk_sel,
    // Outputs
    output flash_prot_pkg::prot_mode_t prot_mode,
    output logic mode_cmd_ack,
    output logic mode_cmd_nak,
    output logic debug_enable,
    output flash_prot_pkg::flash_rsp_t flash_rsp,
    output logic [1:0] flash_wait_cycles
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rst_s1_q;
    logic rst_n_q;

    // Two flops release reset cleanly to the rest of the block
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode machine
    flash_prot_pkg::prot_mode_t mode_q;
    flash_prot_pkg::prot_mode_t mode_d;
    logic loaded_q;
    logic erased_q;
    logic ack_q;
    logic nak_q;

    // Legal transitions decode
    wire cmd_go = mode_cmd_valid && loaded_q;
    wire to_prot_ok = (mode_q == flash_prot_pkg::MODE_OPEN)
        && (mode_cmd == flash_prot_pkg::CMD_TO_PROTECTED);
    wire to_open_ok = (mode_q == flash_prot_pkg::MODE_PROTECTED)
        && (mode_cmd == flash_prot_pkg::CMD_TO_OPEN) && erased_q;
    wire to_kill_ok = (mode_q == flash_prot_pkg::MODE_OPEN)
        && (mode_cmd == flash_prot_pkg::CMD_TO_KILL);
    wire cmd_ok = to_prot_ok || to_open_ok || to_kill_ok;

    // Next mode; anything else, including every request in kill, keeps the mode
    always_comb begin
        mode_d = mode_q;
        if (!loaded_q && stored_mode_valid) begin
            mode_d = stored_mode;
        end else if (cmd_go && cmd_ok) begin
            unique case (mode_cmd)
                flash_prot_pkg::CMD_TO_PROTECTED: mode_d = flash_prot_pkg::MODE_PROTECTED;
                flash_prot_pkg::CMD_TO_OPEN: mode_d = flash_prot_pkg::MODE_OPEN;
                flash_prot_pkg::CMD_TO_KILL: mode_d = flash_prot_pkg::MODE_KILL;
                flash_prot_pkg::CMD_NONE: mode_d = mode_q;
            endcase
        end
    end

    // Erase latch: set by full erase in protected mode, cleared on leaving it.
    // Set is tested first, but set and clear never meet: an erase while the mode is still open is not recorded.
    wire erase_clr = (mode_q != flash_prot_pkg::MODE_PROTECTED);

    // Mode register starts open; stored mode is loaded once after release
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= flash_prot_pkg::MODE_RESET;
            loaded_q <= 1'b0;
            erased_q <= 1'b0;
            ack_q <= 1'b0;
            nak_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            loaded_q <= loaded_q | stored_mode_valid;
            if (full_erase_done && mode_q == flash_prot_pkg::MODE_PROTECTED) begin
                erased_q <= 1'b1;
            end else if (erase_clr) begin
                erased_q <= 1'b0;
            end
            ack_q <= cmd_go && cmd_ok;
            nak_q <= cmd_go && !cmd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Row protection table, one write-block and one read-block bit per row
    logic [ROWS-1:0] wr_block_q;
    logic [ROWS-1:0] rd_block_q;

    // Row bits cleared on reset; software reprograms them after boot
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_block_q <= '0;
            rd_block_q <= '0;
        end else if (row_prot_we) begin
            wr_block_q[row_prot_row] <= row_prot_wr_block;
            rd_block_q[row_prot_row] <= row_prot_rd_block;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access decision
    wire dbg_blocked = (mode_q != flash_prot_pkg::MODE_OPEN);
    wire row_blocked = ((flash_req.op == flash_prot_pkg::OP_WRITE) && wr_block_q[flash_req.row])
        || ((flash_req.op == flash_prot_pkg::OP_READ) && rd_block_q[flash_req.row]);
    // Kill forbids external erase so power loss cannot leave half-erased code
    wire ext_erase_kill = flash_req.from_debug && (flash_req.op == flash_prot_pkg::OP_ERASE)
        && (mode_q == flash_prot_pkg::MODE_KILL);
    wire grant = flash_req.from_syscall
        || (!(flash_req.from_debug && dbg_blocked) && !ext_erase_kill && !row_blocked);
    wire [1:0] wait_need = fast_clk_sel ? flash_prot_pkg::WAIT_FAST
        : flash_prot_pkg::WAIT_SLOW;

    logic busy_q;
    logic [1:0] wait_q;
    logic grant_q;
    logic done_q;
    logic rsp_gnt_q;
    logic [1:0] ws_q;

    // Accepted request waits wait_need cycles, then answers with a one-cycle done
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            busy_q <= 1'b0;
            wait_q <= 2'h0;
            grant_q <= 1'b0;
            done_q <= 1'b0;
            rsp_gnt_q <= 1'b0;
            ws_q <= 2'h0;
        end else begin
            ws_q <= wait_need;
            done_q <= 1'b0;
            rsp_gnt_q <= 1'b0; // Granted only stands beside done
            if (!busy_q && flash_req.valid) begin
                busy_q <= (wait_need != 2'h0);
                wait_q <= wait_need;
                grant_q <= grant;
                done_q <= (wait_need == 2'h0);
                rsp_gnt_q <= grant && (wait_need == 2'h0);
            end else if (busy_q) begin
                wait_q <= wait_q - 2'h1;
                if (wait_q == 2'h1) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    rsp_gnt_q <= grant_q;
                end
            end
        end
    end

    // Outputs straight from flops
    assign prot_mode = mode_q;
    assign mode_cmd_ack = ack_q;
    assign mode_cmd_nak = nak_q;
    logic dbg_en_q;
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dbg_en_q <= 1'b1;
        end else begin
            dbg_en_q <= (mode_d == flash_prot_pkg::MODE_OPEN);
        end
    end
    assign debug_enable = dbg_en_q;
    assign flash_rsp = '{done: done_q, granted: rsp_gnt_q};
    assign flash_wait_cycles = ws_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_reset_open;
        @(posedge core_clk) $rose(rst_n_q) |-> mode_q == flash_prot_pkg::MODE_OPEN;
    endproperty
    a_reset_open: assert property (p_reset_open) else $error("Mode not open after reset");

    property p_to_prot;
        @(posedge core_clk) disable iff (!rst_n_q)
        cmd_go && to_prot_ok |=> mode_q == flash_prot_pkg::MODE_PROTECTED && mode_cmd_ack;
    endproperty
    a_to_prot: assert property (p_to_prot) else $error("Open to protected failed");

    property p_dbg_prot;
        @(posedge core_clk) disable iff (!rst_n_q)
        mode_q == flash_prot_pkg::MODE_PROTECTED && flash_req.valid && !busy_q
        && flash_req.from_debug && !flash_req.from_syscall |=> !grant_q;
    endproperty
    a_dbg_prot: assert property (p_dbg_prot) else $error("Debug access in protected");

    property p_open_needs_erase;
        @(posedge core_clk) disable iff (!rst_n_q)
        loaded_q && $past(mode_q) == flash_prot_pkg::MODE_PROTECTED
        && mode_q == flash_prot_pkg::MODE_OPEN |-> $past(erased_q);
    endproperty
    a_open_needs_erase: assert property (p_open_needs_erase) else $error("Unlock without erase");

    property p_to_kill;
        @(posedge core_clk) disable iff (!rst_n_q)
        cmd_go && to_kill_ok |=> mode_q == flash_prot_pkg::MODE_KILL ##1 !debug_enable;
    endproperty
    a_to_kill: assert property (p_to_kill) else $error("Open to kill failed");

    property p_kill_no_dbg;
        @(posedge core_clk) disable iff (!rst_n_q)
        mode_q == flash_prot_pkg::MODE_KILL && loaded_q |=> !debug_enable;
    endproperty
    a_kill_no_dbg: assert property (p_kill_no_dbg) else $error("Debug enabled in kill");

    property p_kill_erase;
        @(posedge core_clk) disable iff (!rst_n_q)
        ext_erase_kill && !flash_req.from_syscall && !busy_q && flash_req.valid |=> !grant_q;
    endproperty
    a_kill_erase: assert property (p_kill_erase) else $error("External erase in kill");

    property p_kill_sticky;
        @(posedge core_clk) disable iff (!rst_n_q)
        mode_q == flash_prot_pkg::MODE_KILL && loaded_q |=> mode_q == flash_prot_pkg::MODE_KILL;
    endproperty
    a_kill_sticky: assert property (p_kill_sticky) else $error("Left kill mode");

    property p_wait_fast;
        @(posedge core_clk) disable iff (!rst_n_q)
        !busy_q && flash_req.valid && fast_clk_sel |=> !done_q ##1 done_q;
    endproperty
    a_wait_fast: assert property (p_wait_fast) else $error("Fast clock wait wrong");

    property p_wait_slow;
        @(posedge core_clk) disable iff (!rst_n_q)
        !busy_q && flash_req.valid && !fast_clk_sel |=> done_q;
    endproperty
    a_wait_slow: assert property (p_wait_slow) else $error("Slow clock wait wrong");

    property p_syscall;
        @(posedge core_clk) disable iff (!rst_n_q)
        !busy_q && flash_req.valid && flash_req.from_syscall |=> grant_q;
    endproperty
    a_syscall: assert property (p_syscall) else $error("System call refused");

    property p_bad_cmd;
        @(posedge core_clk) disable iff (!rst_n_q)
        cmd_go && !cmd_ok |=> mode_cmd_nak && mode_q == $past(mode_q);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("Illegal command changed mode");

    c_prot: cover property (@(posedge core_clk) mode_q == flash_prot_pkg::MODE_PROTECTED);
    c_unlock: cover property (@(posedge core_clk) cmd_go && to_open_ok);
    c_kill: cover property (@(posedge core_clk) mode_q == flash_prot_pkg::MODE_KILL);
    c_row_block: cover property (@(posedge core_clk) flash_req.valid && row_blocked);
endmodule : flash_protection_mode_control

// file: test/debug_probe_model.sv
// Partner model: debug probe on the flash request port
`timescale 1ns/1ps
module debug_probe_model (
    // Clock, request out, answer back
    input wire logic core_clk,
    output flash_prot_pkg::flash_req_t req,
    input wire flash_prot_pkg::flash_rsp_t rsp
);
    initial req = '0;
    ////////////////
    // One access; dbg low is a system call. Fields invert once taken so none look live
    task automatic access(input logic [1:0] op, input logic [8:0] row, input logic dbg,
                          output logic g, output int lat);
        lat = 1; // Edges from the taking edge to the one that shows done
        @(posedge core_clk) #1;
        req = {1'b1, op, dbg, !dbg, row};
        @(posedge core_clk) #1;
        req = {1'b0, ~op, !dbg, dbg, ~row};
        while (rsp.done !== 1'b1 && lat < 4) begin
            @(posedge core_clk) #1;
            lat++;
        end
        g = rsp.granted;
    endtask : access
endmodule : debug_probe_model

// file: test/testbench.sv
// Self-checking bench for flash protection mode control
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, mode_cmd_valid = 1'b0;
    logic stored_mode_valid = 1'b0, full_erase_done = 1'b0, fast_clk_sel = 1'b0;
    logic row_prot_we = 1'b0, row_prot_wr_block = 1'b0, row_prot_rd_block = 1'b0;
    logic [8:0] row_prot_row = 9'h000;
    logic [1:0] cmd_raw = 2'h0, stored_raw = 2'h0;
    flash_prot_pkg::flash_req_t flash_req;
    flash_prot_pkg::flash_rsp_t flash_rsp;
    flash_prot_pkg::prot_mode_t prot_mode;
    logic mode_cmd_ack, mode_cmd_nak, debug_enable;
    logic [1:0] flash_wait_cycles;
    int tests_run = 0, miscompares = 0;
    ////////////////
    // Design and probe; the restored mode starts at the factory state
    flash_protection_mode_control dut_u (
        .core_clk, .nrst, .mode_cmd(flash_prot_pkg::mode_cmd_t'(cmd_raw)), .mode_cmd_valid,
        .stored_mode_valid, .stored_mode(flash_prot_pkg::prot_mode_t'(stored_raw)),
        .full_erase_done,
        .row_prot_we, .row_prot_row, .row_prot_wr_block, .row_prot_rd_block, .flash_req,
        .fast_clk_sel, .prot_mode, .mode_cmd_ack, .mode_cmd_nak, .debug_enable, .flash_rsp,
        .flash_wait_cycles);
    debug_probe_model probe_u (.core_clk(core_clk), .req(flash_req), .rsp(flash_rsp));
    // Clock, and a hang guard far above the hundred or so cycles a run needs
    always #10 core_clk = ~core_clk;
    initial begin
        repeat (3000) @(posedge core_clk);
        miscompares++;
        close_out();
    end
    ////////////////
    // Shared helpers
    task automatic close_out;
        $display("checks %0d wrong %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick;
        @(posedge core_clk) #1;
    endtask : tick
    // Answer and mode checked just after the taking edge, pulse end and debug gate one edge later
    task automatic send_cmd(input logic [1:0] c, input logic ok, input logic [1:0] m);
        tick();
        {cmd_raw, mode_cmd_valid} = {c, 1'b1};
        tick();
        mode_cmd_valid = 1'b0;
        check("answer", {mode_cmd_ack, mode_cmd_nak}, {ok, !ok});
        check("mode", prot_mode, m);
        tick();
        check("answer pulse", mode_cmd_ack | mode_cmd_nak, 1'b0);
        check("debug gate", debug_enable, m == 2'h0);
    endtask : send_cmd
    task automatic acc(input logic [1:0] op, input logic [8:0] row, input logic dbg, input logic ge);
        logic g;
        int lat;
        probe_u.access(op, row, dbg, g, lat);
        check("granted", g, ge);
        check("latency", lat[15:0], fast_clk_sel ? 16'h2 : 16'h1);
    endtask : acc
    task automatic prot_row(input logic [8:0] r, input logic wr, input logic rd);
        tick();
        {row_prot_we, row_prot_row, row_prot_wr_block, row_prot_rd_block} = {1'b1, r, wr, rd};
        tick();
        row_prot_we = 1'b0;
    endtask : prot_row
    task automatic erase_all;
        tick();
        full_erase_done = 1'b1;
        tick();
        full_erase_done = 1'b0;
    endtask : erase_all
    // Factory state, then both clock rates
    task automatic t_open_waits;
        check("reset mode", prot_mode, 2'h0);
        check("debug open", debug_enable, 1'b1);
        check("wait slow", flash_wait_cycles, 2'h0);
        acc(2'h2, 9'h000, 1'b1, 1'b1);
        fast_clk_sel = 1'b1;
        repeat (3) tick();
        check("wait fast", flash_wait_cycles, 2'h1);
        acc(2'h1, 9'h020, 1'b1, 1'b1);
    endtask : t_open_waits
    // Each block bit blocks its own row; the write block is shown acting alone and being cleared
    task automatic t_rows;
        prot_row(9'h005, 1'b1, 1'b0);
        acc(2'h1, 9'h005, 1'b1, 1'b0);
        acc(2'h0, 9'h005, 1'b1, 1'b1);
        acc(2'h1, 9'h006, 1'b1, 1'b1);
        prot_row(9'h1ff, 1'b0, 1'b1);
        acc(2'h0, 9'h1ff, 1'b1, 1'b0);
        prot_row(9'h005, 1'b0, 1'b0);
        acc(2'h1, 9'h005, 1'b1, 1'b1);
    endtask : t_rows
    // Every command refused while locked, until a full erase has finished
    task automatic t_protect;
        send_cmd(2'h1, 1'b1, 2'h1);
        acc(2'h0, 9'h007, 1'b1, 1'b0);
        acc(2'h1, 9'h007, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++) send_cmd(k[1:0], 1'b0, 2'h1);
        erase_all();
        send_cmd(2'h2, 1'b1, 2'h0);
        acc(2'h0, 9'h007, 1'b1, 1'b1);
    endtask : t_protect
    // Permanent lock: no debug access, no external erase, no way out
    task automatic t_kill;
        send_cmd(2'h3, 1'b1, 2'h3);
        acc(2'h0, 9'h008, 1'b1, 1'b0);
        acc(2'h2, 9'h008, 1'b1, 1'b0);
        acc(2'h2, 9'h008, 1'b0, 1'b1);
        erase_all();
        for (int k = 0; k < 4; k++) send_cmd(k[1:0], 1'b0, 2'h3);
    endtask : t_kill
    // Mid-run reset with a killed part on record: the restored mode stays locked
    task automatic t_restore;
        nrst = 1'b0;
        stored_mode_valid = 1'b0;
        stored_raw = 2'h3;
        tick();
        check("reset mode again", prot_mode, 2'h0);
        nrst = 1'b1;
        repeat (3) tick();
        stored_mode_valid = 1'b1;
        repeat (3) tick();
        check("restored mode", prot_mode, 2'h3);
        check("restored gate", debug_enable, 1'b0);
        send_cmd(2'h2, 1'b0, 2'h3);
        acc(2'h1, 9'h009, 1'b1, 1'b0);
    endtask : t_restore
    ////////////////
    // Reset for 12 cycles, restore the stored mode, then run the scenarios
    initial begin
        repeat (12) tick();
        nrst = 1'b1;
        repeat (3) tick();
        stored_mode_valid = 1'b1;
        repeat (3) tick();
        t_open_waits();
        t_rows();
        t_protect();
        t_kill();
        t_restore();
        close_out();
    end
endmodule : testbench
